/* tit_pkg.sv */
// package for the trap instruction transform block
// assumes a 32-bit instruction path from the hart pipeline
package tit_pkg;
  localparam int unsigned XW = 32;
  // opcodes of the full-width instruction classes handled here
  localparam logic [6:0] OP_LOAD    = 7'h03;
  localparam logic [6:0] OP_LOAD_FP = 7'h07;
  localparam logic [6:0] OP_STORE   = 7'h23;
  localparam logic [6:0] OP_STOREFP = 7'h27;
  localparam logic [6:0] OP_AMO     = 7'h2f;
  localparam logic [6:0] OP_SYSTEM  = 7'h73;
  // funct3 and funct7 marking the hypervisor virtual-machine accesses
  localparam logic [2:0] F3_HYPV    = 3'h4;
  localparam logic [6:0] F7_HYP_LO  = 7'h30;
  localparam logic [6:0] F7_HYP_HI  = 7'h37;
  // field positions
  localparam int unsigned OFF_LSB   = 15;
  localparam int unsigned OFF_MSB   = 19;
  // pseudoinstruction values for VS-stage translation accesses
  localparam logic [31:0] PSEUDO_RD32 = 32'h0000_2000;
  localparam logic [31:0] PSEUDO_WR32 = 32'h0000_2020;
  localparam logic [31:0] PSEUDO_RD64 = 32'h0000_3000;
  localparam logic [31:0] PSEUDO_WR64 = 32'h0000_3020;
  localparam logic [1:0]  WIDTH_32  = 2'h1;
  localparam logic [1:0]  WIDTH_64  = 2'h2;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  typedef enum logic [1:0] {
    TIT_KIND_NONE,
    TIT_KIND_LOAD,
    TIT_KIND_STORE,
    TIT_KIND_KEEP
  } tit_kind_t;
endpackage

/* tit_exp_if.sv */
// carries a compressed instruction to the expander and the expansion back
// assumes both ends run combinationally in the same clock domain
`timescale 1ns/1ns
interface tit_exp_if;
  logic [15:0] half;
  logic [31:0] full;
  logic        valid;
  modport req (output half, input full, input valid);
  modport rsp (input half, output full, output valid);
endinterface

/* tit_expand.sv */
// expands compressed memory-access instructions to their 32-bit form
// assumes only the load and store compressed forms need expansion
`timescale 1ns/1ns
module tit_expand
  import tit_pkg::*;
(
  tit_exp_if.rsp port_x
);
  logic [15:0] c;
  logic [4:0]  rd_p;
  logic [4:0]  rs2_p;
  logic [4:0]  rs1_p;
  assign c     = port_x.half;
  assign rd_p  = {2'h1, c[4:2]};
  assign rs2_p = {2'h1, c[4:2]};
  assign rs1_p = {2'h1, c[9:7]};
  // ==========================================================
  // expansion of load and store forms; other forms report invalid
  always_comb begin
    port_x.full  = ZERO_WORD;
    port_x.valid = 1'b0;
    case ({c[15:13], c[1:0]})
      5'h08: begin // c.lw
        port_x.full  = {5'h0, c[5], c[12:10], c[6], 2'h0, rs1_p, 3'h2, rd_p, OP_LOAD};
        port_x.valid = 1'b1;
      end
      5'h0c: begin // c.ld
        port_x.full  = {4'h0, c[6:5], c[12:10], 3'h0, rs1_p, 3'h3, rd_p, OP_LOAD};
        port_x.valid = 1'b1;
      end
      5'h04: begin // c.fld
        port_x.full  = {4'h0, c[6:5], c[12:10], 3'h0, rs1_p, 3'h3, rd_p, OP_LOAD_FP};
        port_x.valid = 1'b1;
      end
      5'h18: begin // c.sw
        port_x.full  = {5'h0, c[5], c[12], rs2_p, rs1_p, 3'h2, c[11:10], c[6], 2'h0,
                        OP_STORE};
        port_x.valid = 1'b1;
      end
      5'h1c: begin // c.sd
        port_x.full  = {4'h0, c[6:5], c[12], rs2_p, rs1_p, 3'h3, c[11:10], 3'h0, OP_STORE};
        port_x.valid = 1'b1;
      end
      5'h14: begin // c.fsd
        port_x.full  = {4'h0, c[6:5], c[12], rs2_p, rs1_p, 3'h3, c[11:10], 3'h0,
                        OP_STOREFP};
        port_x.valid = 1'b1;
      end
      5'h0a: begin // c.lwsp
        port_x.full  = {4'h0, c[3:2], c[12], c[6:4], 2'h0, 5'h02, 3'h2, c[11:7], OP_LOAD};
        port_x.valid = (c[11:7] != 5'h00);
      end
      5'h0e: begin // c.ldsp
        port_x.full  = {3'h0, c[4:2], c[12], c[6:5], 3'h0, 5'h02, 3'h3, c[11:7], OP_LOAD};
        port_x.valid = (c[11:7] != 5'h00);
      end
      5'h1a: begin // c.swsp
        port_x.full  = {4'h0, c[8:7], c[12], c[6:2], 5'h02, 3'h2, c[11:9], 2'h0, OP_STORE};
        port_x.valid = 1'b1;
      end
      5'h1e: begin // c.sdsp
        port_x.full  = {3'h0, c[9:7], c[12], c[6:2], 5'h02, 3'h3, c[11:10], 3'h0, OP_STORE};
        port_x.valid = 1'b1;
      end
      default: begin
        port_x.full  = ZERO_WORD;
        port_x.valid = 1'b0;
      end
    endcase
  end
endmodule

/* tit_trap_instr.sv */
// trap instruction value former for machine and hypervisor trap entry
// assumes the pipeline raises one-cycle trap strobes with stable fields
//
// Behaviour
// [RULE_01] atomics keep all fields except bits 19:15, which carry the offset
// [RULE_02] hypervisor virtual loads and stores keep fields, offset in 19:15
// [RULE_03] offset is fault address minus original access address
// [RULE_04] basic loads and stores get their immediate fields zeroed
// [RULE_05] compressed: expand, transform, then clear bit 1
// [RULE_06] bits 1:0 read 01 for compressed, 11 for full width
// [RULE_07] implicit VS-stage fault with nonzero guest address writes pseudo value
// [RULE_08] 64-bit guest width: 0x00003000 read, 0x00003020 write
// [RULE_09] 32-bit guest width: 0x00002000 read, 0x00002020 write
// [RULE_10] pseudo set chosen by guest kernel width, not host width
// [RULE_11] write pseudo only for hardware A/D updates, otherwise read
// [RULE_12] pseudo value is x0 load/store word/double encoding with bits 1:0 zero
// [RULE_13] registers hold pseudo values and are not hardwired to zero
// [RULE_14] registers hold full values, a superset of the minimum set
// [RULE_15] interrupts write zero
// [RULE_16] untransformable synchronous traps write zero
// [RULE_17] full load keeps funct3, rd, opcode; offset 19:15; zero 31:20
// [RULE_18] full store keeps rs2, funct3, opcode; offset 19:15; zero 31:25, 11:7
// [RULE_19] register updates in the trap entry cycle with cause and value
`timescale 1ns/1ns
module tit_trap_instr
  import tit_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // trap entry from the pipeline
  input  wire logic        trap_take,
  input  wire logic        trap_to_hyp,
  input  wire logic        trap_is_irq,
  input  wire logic [31:0] trap_instr,
  input  wire logic [63:0] trap_fault_addr,
  input  wire logic [63:0] trap_orig_addr,
  // guest-page fault detail
  input  wire logic        guest_fault,
  input  wire logic        guest_implicit,
  input  wire logic        guest_ad_update,
  input  wire logic [63:0] machine_guest_addr_reg,
  input  wire logic [1:0]  guest_kernel_width,
  // trap instruction registers
  output      logic [31:0] mach_tinst,
  output      logic [31:0] hyp_tinst
);
  // ==========================================================
  // instruction field positions
  localparam int unsigned OPC_MSB  = 6;
  localparam int unsigned RD_LSB   = 7;
  localparam int unsigned RD_MSB   = 11;
  localparam int unsigned F3_LSB   = 12;
  localparam int unsigned F3_MSB   = 14;
  localparam int unsigned RS2_LSB  = 20;
  localparam int unsigned RS2_MSB  = 24;
  localparam int unsigned F7_LSB   = 25;
  localparam int unsigned F7_MSB   = 31;
  localparam int unsigned C_BIT    = 1;
  localparam logic [1:0]  LOW_FULL = 2'h3;

  // ==========================================================
  // helpers
  // hypervisor virtual-machine loads and stores sit in the system opcode
  function automatic logic is_hyp_access(input logic [31:0] i);
    return i[OPC_MSB:0] == OP_SYSTEM && i[F3_MSB:F3_LSB] == F3_HYPV &&
           i[F7_MSB:F7_LSB] >= F7_HYP_LO && i[F7_MSB:F7_LSB] <= F7_HYP_HI;
  endfunction

  function automatic tit_kind_t classify(input logic [31:0] i);
    tit_kind_t k;
    k = TIT_KIND_NONE;
    case (i[OPC_MSB:0])
      OP_LOAD, OP_LOAD_FP:   k = TIT_KIND_LOAD;
      OP_STORE, OP_STOREFP:  k = TIT_KIND_STORE;
      OP_AMO:                k = TIT_KIND_KEEP;
      OP_SYSTEM:             k = is_hyp_access(i) ? TIT_KIND_KEEP : TIT_KIND_NONE;
      default:               k = TIT_KIND_NONE;
    endcase
    return k;
  endfunction

  function automatic logic [31:0] put_offset(input logic [31:0] i, input logic [4:0] off);
    logic [31:0] r;
    r = i;
    r[OFF_MSB:OFF_LSB] = off;
    return r;
  endfunction

  // loads keep funct3, rd and opcode; rs1 and the immediate give way
  function automatic logic [31:0] form_load(input logic [31:0] i, input logic [4:0] off);
    logic [31:0] r;
    r = ZERO_WORD;
    r[F3_MSB:0]        = i[F3_MSB:0];
    r[OFF_MSB:OFF_LSB] = off;
    return r;
  endfunction

  // stores keep rs2, funct3 and opcode; both immediate parts read zero
  function automatic logic [31:0] form_store(input logic [31:0] i, input logic [4:0] off);
    logic [31:0] r;
    r = ZERO_WORD;
    r[RS2_MSB:RS2_LSB] = i[RS2_MSB:RS2_LSB];
    r[OFF_MSB:OFF_LSB] = off;
    r[F3_MSB:F3_LSB]   = i[F3_MSB:F3_LSB];
    r[RD_MSB:RD_LSB]   = 5'h00;
    r[OPC_MSB:0]       = i[OPC_MSB:0];
    return r;
  endfunction

  // distance of the faulting byte from the access start; only a misaligned
  // access makes it nonzero, so its low five bits carry all of it
  function automatic logic [4:0] addr_offset(input logic [63:0] fault,
                                             input logic [63:0] orig);
    logic [63:0] d;
    d = fault - orig;
    return d[OFF_MSB-OFF_LSB:0];
  endfunction

  // unknown widths fall back to the 64-bit set, the wider guest being the default
  function automatic logic [31:0] pick_pseudo(input logic [1:0] w, input logic wr);
    logic [31:0] p;
    p = ZERO_WORD;
    case (w)
      WIDTH_32: p = wr ? PSEUDO_WR32 : PSEUDO_RD32; // RULE_09 RULE_11
      WIDTH_64: p = wr ? PSEUDO_WR64 : PSEUDO_RD64; // RULE_08 RULE_11
      default:  p = wr ? PSEUDO_WR64 : PSEUDO_RD64; // RULE_12
    endcase
    return p;
  endfunction

  // ==========================================================
  // compressed expansion
  tit_exp_if exp_x ();
  tit_expand u_expand (
    .port_x (exp_x)
  );
  assign exp_x.half = trap_instr[15:0];

  logic        is_comp;
  logic [31:0] base_instr;
  logic        base_ok;
  assign is_comp    = (trap_instr[1:0] != LOW_FULL);
  assign base_instr = is_comp ? exp_x.full : trap_instr; // RULE_05
  assign base_ok    = is_comp ? exp_x.valid : 1'b1;

  // ==========================================================
  // address offset
  logic [4:0]  offset;
  assign offset = addr_offset(trap_fault_addr, trap_orig_addr); // RULE_03

  // ==========================================================
  // transformation
  tit_kind_t   kind;
  logic [31:0] xform;
  logic [31:0] pseudo;
  logic        use_pseudo;
  logic [31:0] value_next;

  assign kind = classify(base_instr);

  always_comb begin
    xform = ZERO_WORD;
    case (kind)
      TIT_KIND_LOAD: begin
        xform = form_load(base_instr, offset); // RULE_17 RULE_04
      end
      TIT_KIND_STORE: begin
        xform = form_store(base_instr, offset); // RULE_18 RULE_04
      end
      TIT_KIND_KEEP: begin
        xform = put_offset(base_instr, offset); // RULE_01 RULE_02
      end
      default: begin
        xform = ZERO_WORD; // RULE_16
      end
    endcase
    if (!base_ok)
      xform = ZERO_WORD; // RULE_16
    else if (is_comp && kind != TIT_KIND_NONE)
      xform[C_BIT] = 1'b0; // RULE_05 RULE_06
  end

  // pseudoinstruction selection by guest width and access type
  always_comb begin
    pseudo = pick_pseudo(guest_kernel_width, guest_ad_update); // RULE_10
  end

  // a zero guest address means no second-stage address was kept: transform as usual
  assign use_pseudo = guest_fault && guest_implicit &&
                      (machine_guest_addr_reg != 64'h0); // RULE_07

  // interrupts win over everything, then pseudo values, then the transform
  always_comb begin
    if (trap_is_irq)
      value_next = ZERO_WORD; // RULE_15
    else if (use_pseudo)
      value_next = pseudo; // RULE_07
    else
      value_next = xform;
  end

  // ==========================================================
  // trap instruction registers
  // full-width registers instead of the minimal one or two flops: every value fits
  // each register changes only on a trap aimed at it
  logic [31:0] mach_tinst_reg;
  logic [31:0] hyp_tinst_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mach_tinst_reg <= ZERO_WORD;
    end else if (trap_take && !trap_to_hyp) begin
      mach_tinst_reg <= value_next; // RULE_19 RULE_13 RULE_14
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hyp_tinst_reg <= ZERO_WORD;
    end else if (trap_take && trap_to_hyp) begin
      hyp_tinst_reg <= value_next; // RULE_19 RULE_13
    end
  end

  assign mach_tinst = mach_tinst_reg;
  assign hyp_tinst  = hyp_tinst_reg;
endmodule

/* tit_trap_instr_monitor.sv */
// assertions on the trap instruction registers
// assumes one-cycle trap strobes and outputs one cycle after them
`timescale 1ns/1ns
module tit_trap_instr_monitor
  import tit_pkg::*;
(
  // clock, reset, trap entry
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        trap_take,
  input wire logic        trap_to_hyp,
  input wire logic        trap_is_irq,
  input wire logic [31:0] trap_instr,
  input wire logic [63:0] trap_fault_addr,
  input wire logic [63:0] trap_orig_addr,
  // guest fault detail
  input wire logic        guest_fault,
  input wire logic        guest_implicit,
  input wire logic        guest_ad_update,
  input wire logic [63:0] machine_guest_addr_reg,
  input wire logic [1:0]  guest_kernel_width,
  // registers
  input wire logic [31:0] mach_tinst,
  input wire logic [31:0] hyp_tinst
);
  logic        hyp_q;
  logic [31:0] ins_q;
  logic [4:0]  off_q;
  wire  [31:0] sel = hyp_q ? hyp_tinst : mach_tinst;
  wire  [63:0] dif = trap_fault_addr - trap_orig_addr;
  wire         tk  = trap_take && !trap_is_irq;
  wire         pz  = tk && guest_fault && guest_implicit && machine_guest_addr_reg != 64'h0;
  wire         w32 = guest_kernel_width == WIDTH_32;
  wire         fw  = tk && !pz && trap_instr[1:0] == 2'h3;
  wire  [6:0]  op  = trap_instr[6:0];
  wire  [6:0]  f7  = trap_instr[31:25];
  wire         kp  = op == OP_AMO || (op == OP_SYSTEM && trap_instr[14:12] == F3_HYPV
                     && f7 >= F7_HYP_LO && f7 <= F7_HYP_HI);
  // remembers the trap so the next cycle can be judged
  always_ff @(posedge clock) begin
    hyp_q <= trap_to_hyp;
    ins_q <= trap_instr;
    off_q <= dif[4:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_irq_writes_zero: assert property (trap_take && trap_is_irq |=> sel == ZERO_WORD)
    else $error("interrupt left a nonzero value");
  a_pseudo_rd64: assert property (pz && !guest_ad_update && !w32 |=> sel == PSEUDO_RD64)
    else $error("wrong 64-bit read pseudo value");
  a_pseudo_wr64: assert property (pz && guest_ad_update && !w32 |=> sel == PSEUDO_WR64)
    else $error("wrong 64-bit write pseudo value");
  a_pseudo_rd32: assert property (pz && !guest_ad_update && w32 |=> sel == PSEUDO_RD32)
    else $error("wrong 32-bit read pseudo value");
  a_pseudo_wr32: assert property (pz && guest_ad_update && w32 |=> sel == PSEUDO_WR32)
    else $error("wrong 32-bit write pseudo value");
  a_load_form: assert property (fw && op == OP_LOAD |=> sel == {12'h0, off_q, ins_q[14:0]})
    else $error("wrong load transform");
  a_store_form: assert property (fw && op == OP_STORE |=>
    sel == {7'h0, ins_q[24:20], off_q, ins_q[14:12], 5'h0, ins_q[6:0]})
    else $error("wrong store transform");
  a_keep_fields: assert property (fw && kp |=> sel == {ins_q[31:20], off_q, ins_q[14:0]})
    else $error("wrong atomic or virtual access transform");
  a_short_lowbits: assert property (tk && !pz && trap_instr[1:0] != 2'h3 ##1
    sel != ZERO_WORD |-> sel[1:0] == 2'h1)
    else $error("compressed transform low bits wrong");
  a_other_stable: assert property (trap_take && !trap_to_hyp |=> $stable(hyp_tinst))
    else $error("hypervisor register changed on machine trap");
  cover property (pz);
  cover property (fw && kp);
  cover property (tk && trap_instr[1:0] != 2'h3);
endmodule

/* tit_pipe_model.sv */
// pipeline model raising trap entries toward the transform block
// assumes calls come at the falling clock edge, one trap per cycle
`timescale 1ns/1ns
module tit_pipe_model (
  // clock
  input  wire logic   clock,
  // trap entry and guest fault detail
  output logic        trap_take,
  output logic        trap_to_hyp,
  output logic        trap_is_irq,
  output logic [31:0] trap_instr,
  output logic [63:0] trap_fault_addr,
  output logic [63:0] trap_orig_addr,
  output logic        guest_fault,
  output logic        guest_implicit,
  output logic        guest_ad_update,
  output logic [63:0] machine_guest_addr_reg,
  output logic [1:0]  guest_kernel_width
);
  initial begin
    {trap_take, trap_to_hyp, trap_is_irq, guest_fault, guest_implicit, guest_ad_update} = 6'h0;
    {trap_instr, trap_fault_addr, trap_orig_addr, machine_guest_addr_reg} = '0;
    guest_kernel_width = 2'h2;
  end
  task automatic issue(input logic h, i, input logic [31:0] ins, input logic [4:0] off,
      input logic g, ad, input logic [1:0] w);
    trap_take = 1'b1;
    {trap_to_hyp, trap_is_irq, trap_instr} = {h, i, ins};
    trap_orig_addr = {$urandom, $urandom};
    trap_fault_addr = trap_orig_addr + {59'h0, off};
    {guest_fault, guest_implicit, guest_ad_update, guest_kernel_width} = {g, g, ad, w};
    machine_guest_addr_reg = g ? {32'h0, $urandom | 32'h1} : 64'h0;
    @(negedge clock);
  endtask
  // the instruction and fault address show inverted values, not the last trap
  task automatic idle;
    trap_take = 1'b0;
    trap_instr = ~trap_instr;
    trap_fault_addr = ~trap_fault_addr;
  endtask
endmodule

/* tit_trap_instr_tb.sv */
// self-checking bench for the trap instruction transform block
// assumes the pipeline model drives every trap input
`timescale 1ns/1ns
module tit_trap_instr_tb;
  import tit_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  wire logic trap_take, trap_to_hyp, trap_is_irq, guest_fault, guest_implicit, guest_ad_update;
  wire logic [31:0] trap_instr, mach_tinst, hyp_tinst;
  wire logic [63:0] trap_fault_addr, trap_orig_addr, machine_guest_addr_reg;
  wire logic [1:0]  guest_kernel_width;
  logic [32:0] exp_q[$];
  logic        took = 1'b0;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  tit_trap_instr DUT (.clock, .resetn, .trap_take, .trap_to_hyp, .trap_is_irq, .trap_instr,
    .trap_fault_addr, .trap_orig_addr, .guest_fault, .guest_implicit, .guest_ad_update,
    .machine_guest_addr_reg, .guest_kernel_width, .mach_tinst, .hyp_tinst);
  tit_pipe_model PM (.clock, .trap_take, .trap_to_hyp, .trap_is_irq, .trap_instr,
    .trap_fault_addr, .trap_orig_addr, .guest_fault, .guest_implicit, .guest_ad_update,
    .machine_guest_addr_reg, .guest_kernel_width);
  always #10 clock = ~clock;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // notes the expected value, then raises the trap
  task automatic t(input logic h, i, input logic [31:0] ins, input logic [4:0] off,
      input logic g, ad, input logic [1:0] w, input logic [31:0] e);
    exp_q.push_back({h, e});
    PM.issue(h, i, ins, off, g, ad, w);
  endtask
  always @(posedge clock) took <= trap_take;
  // =====================================
  // result watcher
  always @(negedge clock) if (took) begin
    logic [32:0] e;
    e = exp_q.pop_front();
    check("tinst", e[31:0], e[32] ? hyp_tinst : mach_tinst);
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] r;
    logic [2:0]  f;
    void'($urandom(32'ha943f119));
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    t(0, 0, 32'h00852283, 5'd2, 0, 0, 2'h2, 32'h00012283);
    t(1, 0, 32'h02532423, 5'd3, 0, 0, 2'h2, 32'h0051a023);
    t(0, 0, 32'h0421a0af, 5'd4, 0, 0, 2'h2, 32'h042220af);
    t(1, 0, 32'h6803c4f3, 5'd0, 0, 0, 2'h2, 32'h680044f3);
    t(0, 0, 32'h00004188, 5'd1, 0, 0, 2'h2, 32'h0000a501);
    t(1, 0, 32'h0000c044, 5'd2, 0, 0, 2'h2, 32'h00912021);
    t(0, 0, 32'h00000505, 5'd0, 0, 0, 2'h2, ZERO_WORD);
    t(0, 1, 32'h00852283, 5'd2, 0, 0, 2'h2, ZERO_WORD);
    t(1, 0, 32'h00100093, 5'd0, 0, 0, 2'h2, ZERO_WORD);
    $display("directed traps done");
    for (int k = 0; k < 4; k++) begin
      t(k[0], 0, 32'h00852283, 5'd0, 1, k[1], k[0] ? WIDTH_32 : WIDTH_64,
        32'h2000 | {19'h0, ~k[0], 6'h0, k[1], 5'h0});
    end
    $display("pseudo values done");
    for (int k = 0; k < 24; k++) begin
      r = $urandom;
      f = r[14:12] % 3'h7;
      t(r[20], 0, {r[31:15], f, r[11:7], 7'h03}, r[4:0], 0, 0, 2'h2,
        {12'h0, r[4:0], f, r[11:7], 7'h03});
    end
    PM.idle();
    repeat (3) @(negedge clock);
    $display("random loads done");
    wrap_up();
  end
endmodule
bind tit_trap_instr tit_trap_instr_monitor MON (.clock, .resetn, .trap_take, .trap_to_hyp,
  .trap_is_irq, .trap_instr, .trap_fault_addr, .trap_orig_addr, .guest_fault, .guest_implicit,
  .guest_ad_update, .machine_guest_addr_reg, .guest_kernel_width, .mach_tinst, .hyp_tinst);
